// ---- core/ahsc_core.sv ----
// Control pin decoder, sample path and APB registers of the amplifier
`timescale 1ns/1ps
module ahsc_core
  import ahsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pins
  input wire logic switch_rate_select_pin,
  input wire logic parallel_load_select_pin,
  input wire logic speaker_sleep_pin,
  input wire logic [1:0] speaker_gain_pins,
  input wire logic speaker_shutdown_pin,
  // Clip level, digitised as a fraction of the supply (256 = supply)
  input wire logic [7:0] soft_clip_level_pin,
  // Samples from the serial audio port
  input wire logic audio_valid,
  output logic audio_ready,
  input wire logic [15:0] audio_left,
  input wire logic [15:0] audio_right,
  // Duty words to the modulator
  output logic duty_valid,
  input wire logic duty_ready,
  output logic [15:0] duty_left,
  output logic [15:0] duty_right,
  // Configuration to the power stage
  output logic [4:0] pwm_rate_multiple,
  output logic paralleled_bridge_mode,
  output logic bridge_tied_mode,
  output logic output_highz,
  output logic switching_enable,
  output logic signal_path_run,
  output logic [1:0] analog_gain_code,
  output logic [8:0] analog_gain_tenth_dbv,
  output logic [3:0] digital_boost_db,
  output logic [7:0] volume_db,
  output logic software_control_mode,
  output logic i2s_only,
  output logic single_speed_mode,
  output logic soft_clip_active
);
  function automatic logic [15:0] boost_sat(input logic [15:0] x);
    logic [16:0] dbl;
    dbl = {x, 1'b0};
    if (x[15] != x[14]) begin
      boost_sat = x[15] ? 16'h8000 : 16'h7fff;
    end else begin
      boost_sat = dbl[15:0];
    end
  endfunction

  function automatic logic [15:0] ramp_scale(input logic [15:0] x, input logic [8:0] r);
    logic signed [25:0] prod;
    prod = 26'($signed(x) * $signed({1'b0, r}));
    ramp_scale = prod[23:8];
  endfunction

  function automatic logic [15:0] clip_cap(input logic [15:0] x, input logic on,
                                           input logic [15:0] lim);
    logic [15:0] neg_lim;
    neg_lim = 16'(~lim + 16'h0001);
    if (!on) begin
      clip_cap = x;
    end else if (!x[15] && (x > lim)) begin
      clip_cap = lim;
    end else if (x[15] && ($signed(x) < $signed(neg_lim))) begin
      clip_cap = neg_lim;
    end else begin
      clip_cap = x;
    end
  endfunction

  function automatic logic [8:0] gain_tenths(input logic [1:0] code);
    unique case (code)
      GAIN_19P2: gain_tenths = GAIN_19P2_TENTHS;
      GAIN_22P6: gain_tenths = GAIN_22P6_TENTHS;
      default: gain_tenths = GAIN_25_TENTHS;
    endcase
  endfunction

  // Pin conditioning
  logic [PIN_COUNT-1:0] pins;
  ahsc_pin_filter u_filter (
    .clk(clk),
    .nrst(nrst),
    .pins_raw({speaker_shutdown_pin, speaker_gain_pins, speaker_sleep_pin,
               parallel_load_select_pin, switch_rate_select_pin}),
    .pins_clean(pins)
  );
  wire pin_rate = pins[PIN_RATE];
  wire pin_par = pins[PIN_PAR];
  wire pin_sleep = pins[PIN_SLEEP];
  wire [1:0] pin_gain = pins[PIN_GAIN_LSB +: 2];
  wire pin_run = pins[PIN_SD];

  // Registers and state
  ahsc_state_t state_reg;
  ahsc_state_t state_next;
  logic sw_mode_reg;
  logic [CTRL_WIDTH-1:0] ctrl_reg;
  logic [8:0] ramp_reg;
  logic [8:0] ramp_next;
  logic [7:0] tick_cnt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] slot_reg [2];
  logic head_v_reg;
  logic tail_v_reg;
  logic ready_reg;
  logic [4:0] rate_reg;
  logic par_reg;
  logic highz_reg;
  logic run_reg;
  logic [1:0] gain_reg;
  logic [8:0] gain_db_reg;
  logic clip_on_reg;
  logic btl_reg;
  logic sw_en_reg;
  logic i2s_reg;
  logic ssm_reg;

  // Mode sources: pins in hardware mode, control register in software mode
  wire ramp_tick = (tick_cnt_reg == 8'(RAMP_STEP_CYC - 1));
  wire sleep_req = sw_mode_reg ? ctrl_reg[CTRL_SLEEP_BIT] : pin_sleep;
  wire rate_hi = sw_mode_reg ? ctrl_reg[CTRL_RATE_BIT] : pin_rate;
  wire par_sel = sw_mode_reg ? ctrl_reg[CTRL_PAR_BIT] : pin_par;
  wire [1:0] gain_sel = sw_mode_reg ? ctrl_reg[CTRL_GAIN_LSB +: 2] : pin_gain;
  wire [4:0] rate_sel = rate_hi ? RATE_X8 : RATE_X16;
  wire shut = (state_reg == ST_SHDN);
  wire sleeping = (state_reg == ST_SLEEP);

  // Soft clipper only bites when four times the pin level is under the supply
  wire clip_on = (soft_clip_level_pin < CLIP_ACTIVE_BELOW);
  wire [15:0] clip_lim = {1'b0, soft_clip_level_pin[5:0], 9'h000};

  // Sample path: source select, boost, ramp, clip
  wire [15:0] src_r = par_reg ? audio_left : audio_right;
  wire [15:0] bst_l = boost_sat(audio_left);
  wire [15:0] bst_r = boost_sat(src_r);
  wire [15:0] out_l = clip_cap(ramp_scale(bst_l, ramp_reg), clip_on_reg, clip_lim);
  wire [15:0] out_r = clip_cap(ramp_scale(bst_r, ramp_reg), clip_on_reg, clip_lim);
  wire [31:0] word_in = highz_reg ? 32'h0000_0000 : {out_l, out_r};

  // Two-entry buffer, head drives the outputs directly
  wire push = audio_valid && ready_reg;
  wire pop = head_v_reg && duty_ready;
  wire head_v_next = pop ? (tail_v_reg || push) : (head_v_reg || push);
  wire tail_v_next = pop ? (tail_v_reg && push) : (tail_v_reg || (push && head_v_reg));

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite && pready_reg;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_stat = (paddr == ADDR_STATUS);
  wire hit_clip = (paddr == ADDR_CLIP);
  wire mapped = hit_ctrl || hit_stat || hit_clip;
  wire [31:0] stat_word = {13'h0000, ramp_reg, pins, clip_on_reg, highz_reg,
                           shut, sw_mode_reg};
  wire [31:0] rd_mux = hit_ctrl ? {27'h0000000, ctrl_reg} :
                       hit_stat ? stat_word :
                       hit_clip ? {16'h0000, clip_lim} : 32'h0000_0000;

  // Sequencer: shutdown overrides everything, sleep ramps in and out
  always_comb begin
    state_next = state_reg;
    ramp_next = ramp_reg;
    unique case (state_reg)
      ST_SHDN: begin
        ramp_next = 9'h000;
        if (pin_run) begin
          state_next = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        state_next = sleep_req ? ST_SLEEP : ST_RAMP_UP;
      end
      ST_RAMP_UP: begin
        if (sleep_req) begin
          state_next = ST_RAMP_DOWN;
        end else if (ramp_reg == RAMP_FULL) begin
          state_next = ST_RUN;
        end else if (ramp_tick) begin
          ramp_next = ramp_reg + 9'h001;
        end
      end
      ST_RUN: begin
        if (sleep_req) begin
          state_next = ST_RAMP_DOWN;
        end
      end
      ST_RAMP_DOWN: begin
        if (!sleep_req) begin
          state_next = ST_RAMP_UP;
        end else if (ramp_reg == 9'h000) begin
          state_next = ST_SLEEP;
        end else if (ramp_tick) begin
          ramp_next = ramp_reg - 9'h001;
        end
      end
      ST_SLEEP: begin
        if (!sleep_req) begin
          state_next = ST_RAMP_UP;
        end
      end
    endcase
    if (!pin_run) begin
      state_next = ST_SHDN;
      ramp_next = 9'h000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_SHDN;
      ramp_reg <= 9'h000;
      tick_cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      ramp_reg <= ramp_next;
      tick_cnt_reg <= ramp_tick ? 8'h00 : tick_cnt_reg + 8'h01;
    end
  end

  // Mode is caught once per release, so a later gain change cannot flip it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_mode_reg <= 1'b0;
      i2s_reg <= 1'b1;
      ssm_reg <= 1'b1;
    end else if (state_reg == ST_DECIDE) begin
      sw_mode_reg <= (pin_gain == GAIN_SOFTWARE);
      // Port limits are caught with the mode so they never disagree with it
      i2s_reg <= (pin_gain != GAIN_SOFTWARE);
      ssm_reg <= (pin_gain != GAIN_SOFTWARE);
    end
  end

  // Power stage configuration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_reg <= RATE_X16;
      par_reg <= 1'b0;
      btl_reg <= 1'b1;
      highz_reg <= 1'b1;
      sw_en_reg <= 1'b0;
      run_reg <= 1'b0;
      gain_reg <= GAIN_19P2;
      gain_db_reg <= GAIN_19P2_TENTHS;
      clip_on_reg <= 1'b0;
    end else begin
      rate_reg <= rate_sel;
      par_reg <= par_sel;
      // Complements get their own flops so every pin but the fixed boost and volume leaves a register
      btl_reg <= !par_sel;
      highz_reg <= shut || sleeping;
      sw_en_reg <= !(shut || sleeping);
      run_reg <= !shut;
      gain_reg <= gain_sel;
      gain_db_reg <= gain_tenths(gain_sel);
      clip_on_reg <= clip_on;
    end
  end

  // Buffer storage; shutdown flushes it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      ready_reg <= 1'b0;
      slot_reg[0] <= 32'h0000_0000;
      slot_reg[1] <= 32'h0000_0000;
    end else if (shut) begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      head_v_reg <= head_v_next;
      tail_v_reg <= tail_v_next;
      ready_reg <= !tail_v_next;
      if (pop && tail_v_reg) begin
        slot_reg[0] <= slot_reg[1];
      end else if (push && (pop || !head_v_reg)) begin
        slot_reg[0] <= word_in;
      end
      if (push && ((head_v_reg && !pop) || (pop && tail_v_reg))) begin
        slot_reg[1] <= word_in;
      end
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RESET[CTRL_WIDTH-1:0];
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (apb_setup) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= !mapped;
      end
      if (apb_wr && hit_ctrl) begin
        ctrl_reg <= pwdata[CTRL_WIDTH-1:0];
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign audio_ready = ready_reg;
  assign duty_valid = head_v_reg;
  assign duty_left = slot_reg[0][31:16];
  assign duty_right = slot_reg[0][15:0];
  assign pwm_rate_multiple = rate_reg;
  assign paralleled_bridge_mode = par_reg;
  assign bridge_tied_mode = btl_reg;
  assign output_highz = highz_reg;
  assign switching_enable = sw_en_reg;
  assign signal_path_run = run_reg;
  assign analog_gain_code = gain_reg;
  assign analog_gain_tenth_dbv = gain_db_reg;
  assign digital_boost_db = DIG_BOOST_DB;
  assign volume_db = VOLUME_DEFAULT_DB;
  assign software_control_mode = sw_mode_reg;
  assign i2s_only = i2s_reg;
  assign single_speed_mode = ssm_reg;
  assign soft_clip_active = clip_on_reg;
endmodule

// ---- core/ahsc_pin_filter.sv ----
// Two-stage synchroniser and stability filter for the control pins
`timescale 1ns/1ps
module ahsc_pin_filter
  import ahsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Raw pins and filtered levels
  input wire logic [PIN_COUNT-1:0] pins_raw,
  output logic [PIN_COUNT-1:0] pins_clean
);
  logic [PIN_COUNT-1:0] meta_reg;
  logic [PIN_COUNT-1:0] sync_reg;
  logic [PIN_COUNT-1:0] last_reg;
  logic [PIN_COUNT-1:0] clean_reg;
  logic [7:0] stable_reg;
  logic [7:0] stable_next;
  wire changed = (sync_reg != last_reg);
  wire settled = (stable_reg == 8'(FILTER_CYC - 1));

  // A change anywhere restarts the count, so a glitch never reaches the decoder
  assign stable_next = changed ? 8'h00 : (settled ? stable_reg : stable_reg + 8'h01);
  assign pins_clean = clean_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
      stable_reg <= 8'h00;
      clean_reg <= '0;
    end else begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      stable_reg <= stable_next;
      if (settled && !changed) begin
        clean_reg <= last_reg;
      end
    end
  end
endmodule

// ---- core/ahsc_pkg.sv ----
// Constants, types and behaviour list for the amplifier strap control block
// Behaviour
// - Rate pin low: switch at 16x fs
// - Rate pin high: switch at 8x fs
// - Parallel pin high: channels paralleled, one speaker
// - Parallel pin low: normal two-channel bridge output
// - Paralleled mode sources the left channel slot
// - Sleep high: ramp down into high-impedance output
// - Sleep stops switching, signal path keeps running
// - Gain codes 00/01/10 give 19.2/22.6/25 dBV
// - Digital boost fixed at plus six decibels
// - Gain code 11 selects software control mode
// - Volume defaults to 0 dB, fixed in hardware
// - Soft clipper caps output duty at a maximum set by the clip level pin
// - Clip limit four times pin level, below supply
// - Shutdown pin low shuts down, high releases
// - Hardware mode: I2S framing, single speed only
package ahsc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int FILTER_NS = 1000;
  localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_STEP_NS = 2000;
  localparam int RAMP_STEP_CYC = RAMP_STEP_NS / CLK_PERIOD_NS;
  localparam int PIN_COUNT = 6;
  localparam logic [8:0] RAMP_FULL = 9'h100;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLIP = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_RATE_BIT = 0;
  localparam int CTRL_PAR_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int CTRL_GAIN_LSB = 3;
  localparam int CTRL_WIDTH = 5;
  localparam int STAT_SW_BIT = 0;
  localparam int STAT_SD_BIT = 1;
  localparam int STAT_HIGHZ_BIT = 2;
  localparam int STAT_CLIP_BIT = 3;
  localparam int STAT_PINS_LSB = 4;
  localparam int STAT_RAMP_LSB = 10;
  localparam int PIN_RATE = 0;
  localparam int PIN_PAR = 1;
  localparam int PIN_SLEEP = 2;
  localparam int PIN_GAIN_LSB = 3;
  localparam int PIN_SD = 5;
  localparam logic [1:0] GAIN_19P2 = 2'b00;
  localparam logic [1:0] GAIN_22P6 = 2'b01;
  localparam logic [1:0] GAIN_25 = 2'b10;
  localparam logic [1:0] GAIN_SOFTWARE = 2'b11;
  localparam logic [8:0] GAIN_19P2_TENTHS = 9'h0c0;
  localparam logic [8:0] GAIN_22P6_TENTHS = 9'h0e2;
  localparam logic [8:0] GAIN_25_TENTHS = 9'h0fa;
  localparam logic [3:0] DIG_BOOST_DB = 4'h6;
  localparam logic [7:0] VOLUME_DEFAULT_DB = 8'h00;
  localparam logic [4:0] RATE_X16 = 5'h10;
  localparam logic [4:0] RATE_X8 = 5'h08;
  localparam logic [7:0] CLIP_ACTIVE_BELOW = 8'h40;
  localparam int CLIP_SHIFT = 9;
  typedef enum logic [2:0] {
    ST_SHDN,
    ST_DECIDE,
    ST_RAMP_UP,
    ST_RUN,
    ST_RAMP_DOWN,
    ST_SLEEP
  } ahsc_state_t;
endpackage

// ---- tb/ahsc_core_chk.sv ----
// Concurrent checks on the amplifier strap control ports
`timescale 1ns/1ps
module ahsc_core_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus and pins
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic switch_rate_select_pin,
  input wire logic parallel_load_select_pin,
  input wire logic [1:0] speaker_gain_pins,
  input wire logic [7:0] soft_clip_level_pin,
  // Streams
  input wire logic audio_ready,
  input wire logic duty_valid,
  input wire logic duty_ready,
  input wire logic [15:0] duty_left,
  input wire logic [15:0] duty_right,
  // Configuration
  input wire logic [4:0] pwm_rate_multiple,
  input wire logic paralleled_bridge_mode,
  input wire logic bridge_tied_mode,
  input wire logic output_highz,
  input wire logic switching_enable,
  input wire logic signal_path_run,
  input wire logic [1:0] analog_gain_code,
  input wire logic [8:0] analog_gain_tenth_dbv,
  input wire logic [3:0] digital_boost_db,
  input wire logic [7:0] volume_db,
  input wire logic software_control_mode,
  input wire logic i2s_only,
  input wire logic single_speed_mode,
  input wire logic soft_clip_active
);
  logic [3:0] pins_reg;
  logic [5:0] quiet_reg;
  logic [3:0] pins_now;
  logic [15:0] lim;
  logic settled;
  assign pins_now = {speaker_gain_pins, parallel_load_select_pin, switch_rate_select_pin};
  assign lim = {1'b0, soft_clip_level_pin[5:0], 9'h000};
  // Straps steady long enough to cover filter and decode lag
  assign settled = quiet_reg == 6'h3f && pins_now == pins_reg && !software_control_mode;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins_reg <= 4'h0;
      quiet_reg <= 6'h00;
    end else begin
      pins_reg <= pins_now;
      if (pins_now != pins_reg || !signal_path_run) begin
        quiet_reg <= 6'h00;
      end else if (quiet_reg != 6'h3f) begin
        quiet_reg <= quiet_reg + 6'h01;
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  apb_ready_a: assert property (apb_setup ##1 apb_access |-> pready)
    else $error("access phase without pready");
  rate_pick_a: assert property (settled |->
    pwm_rate_multiple == (switch_rate_select_pin ? 5'h08 : 5'h10))
    else $error("switch rate does not follow pin");
  par_pick_a: assert property (settled |->
    paralleled_bridge_mode == parallel_load_select_pin)
    else $error("output mode does not follow pin");
  mode_pair_a: assert property (paralleled_bridge_mode != bridge_tied_mode)
    else $error("output modes not exclusive");
  gain_dbv_a: assert property (settled |-> analog_gain_code == speaker_gain_pins &&
    analog_gain_tenth_dbv == (analog_gain_code == 2'b00 ? 9'h0c0 :
    analog_gain_code == 2'b01 ? 9'h0e2 : 9'h0fa))
    else $error("gain decode wrong");
  fixed_gain_a: assert property (digital_boost_db == 4'h6 && volume_db == 8'h00)
    else $error("boost or volume not fixed");
  stop_switch_a: assert property (switching_enable != output_highz)
    else $error("switching while high impedance");
  hw_port_a: assert property (!software_control_mode |-> i2s_only && single_speed_mode)
    else $error("audio port mode wrong");
  mode_hold_a: assert property (signal_path_run && $past(signal_path_run, 3) |->
    $stable(software_control_mode))
    else $error("control mode changed while running");
  shut_quiet_a: assert property (!signal_path_run && !$past(signal_path_run) |->
    output_highz && !audio_ready)
    else $error("shutdown not quiet");
  left_source_a: assert property (duty_valid && paralleled_bridge_mode |->
    duty_right == duty_left)
    else $error("paralleled outputs differ");
  clip_cap_a: assert property (duty_valid && soft_clip_active |->
    $signed(duty_left) <= $signed(lim) && $signed(duty_left) >= -$signed(lim))
    else $error("duty above clip limit");
  duty_hold_a: assert property (duty_valid && !duty_ready && signal_path_run |=>
    duty_valid && $stable({duty_left, duty_right}))
    else $error("duty word dropped");
endmodule
bind ahsc_core ahsc_core_chk chk (.*);

// ---- tb/ahsc_host_model.sv ----
// Board straps and host processor model driving the control pins
`timescale 1ns/1ps
module ahsc_host_model #(
  parameter int HOLD = 80
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Requested settings
  input wire logic want_on,
  input wire logic want_rate,
  input wire logic want_par,
  input wire logic want_sleep,
  input wire logic [1:0] want_gain,
  // Control pins
  output logic switch_rate_select_pin,
  output logic parallel_load_select_pin,
  output logic speaker_sleep_pin,
  output logic [1:0] speaker_gain_pins,
  output logic speaker_shutdown_pin
);
  logic [7:0] hold_reg;
  assign switch_rate_select_pin = want_rate;
  assign parallel_load_select_pin = want_par;
  assign speaker_gain_pins = want_gain;
  // Sleep leads every shutdown by HOLD cycles, too few for the ramp down to finish, so switching still stops mid-ramp
  assign speaker_sleep_pin = want_sleep || (!want_on && speaker_shutdown_pin);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_reg <= 8'h00;
      speaker_shutdown_pin <= 1'b0;
    end else if (want_on) begin
      hold_reg <= 8'h00;
      speaker_shutdown_pin <= 1'b1;
    end else if (hold_reg == HOLD[7:0]) begin
      speaker_shutdown_pin <= 1'b0;
    end else begin
      hold_reg <= hold_reg + 8'h01;
    end
  end
endmodule

// ---- tb/tb_amp_hw_strap_control.sv ----
// Self-checking bench for the amplifier strap control block
`timescale 1ns/1ps
module tb_amp_hw_strap_control;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, speaker_sleep_pin, speaker_shutdown_pin;
  logic switch_rate_select_pin, parallel_load_select_pin;
  logic [1:0] speaker_gain_pins, analog_gain_code;
  logic [7:0] soft_clip_level_pin = 8'hff;
  logic audio_valid = 1'b0, audio_ready, duty_valid, duty_ready = 1'b0;
  logic [15:0] audio_left = 16'h0, audio_right = 16'h0, duty_left, duty_right;
  logic [4:0] pwm_rate_multiple;
  logic paralleled_bridge_mode, bridge_tied_mode, output_highz, switching_enable;
  logic signal_path_run, software_control_mode, i2s_only, single_speed_mode;
  logic soft_clip_active;
  logic [8:0] analog_gain_tenth_dbv;
  logic [3:0] digital_boost_db;
  logic [7:0] volume_db;
  logic want_on = 1'b1, want_rate = 1'b0, want_par = 1'b0, want_sleep = 1'b0;
  logic [1:0] want_gain = 2'b01;
  int fail_count = 0, check_count = 0;
  always #25 clk = ~clk;
  ahsc_host_model hm (.*);
  ahsc_core dut (.*);
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_run;
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0, r, e);
      n++;
    end while (r[18:10] !== 9'h100 && n < 5000);
    chk(r[18:10], 9'h100, "ramp end");
  endtask
  task wait_hz(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (output_highz !== v && n < 12000);
  endtask
  task push(input logic [15:0] l);
    audio_valid <= 1'b1;
    audio_left <= l;
    do begin
      @(posedge clk);
    end while (audio_ready !== 1'b1);
    audio_valid <= 1'b0;
  endtask
  task take(input logic [15:0] l, input logic [15:0] r);
    do begin
      @(posedge clk);
    end while (duty_valid !== 1'b1);
    chk({duty_left, duty_right}, {l, r}, "duty words");
  endtask
  task t_hw;
    logic [8:0] tenths [3];
    tenths = '{9'h0c0, 9'h0e2, 9'h0fa};
    wait_run;
    chk(pwm_rate_multiple, 16, "rate low");
    chk({paralleled_bridge_mode, bridge_tied_mode}, 2'b01, "bridge");
    chk({i2s_only, single_speed_mode, software_control_mode}, 3'b110, "port");
    chk({digital_boost_db, volume_db}, 12'h600, "fixed gain");
    want_rate <= 1'b1;
    tick(3);
    want_rate <= 1'b0;
    tick(40);
    chk(pwm_rate_multiple, 16, "glitch");
    want_rate <= 1'b1;
    tick(40);
    chk(pwm_rate_multiple, 8, "rate high");
    want_rate <= 1'b0;
    for (int g = 0; g < 3; g++) begin
      want_gain <= g[1:0];
      tick(40);
      chk(analog_gain_code, g, "gain code");
      chk(analog_gain_tenth_dbv, tenths[g], "gain dBV");
    end
    want_par <= 1'b1;
    tick(40);
    chk({paralleled_bridge_mode, bridge_tied_mode}, 2'b10, "parallel");
    $display("t_hw done");
  endtask
  task t_stream;
    int acc;
    audio_valid <= 1'b1;
    audio_left <= 16'h1000;
    audio_right <= 16'h0777;
    acc = 0;
    for (int n = 0; n < 12; n++) begin
      @(posedge clk);
      if (audio_ready === 1'b1) begin
        acc++;
        audio_left <= 16'h5000;
      end
    end
    audio_valid <= 1'b0;
    chk(acc, 2, "buffer depth");
    duty_ready <= 1'b1;
    take(16'h2000, 16'h2000);
    take(16'h7fff, 16'h7fff);
    $display("t_stream done");
  endtask
  task t_clip;
    logic [31:0] r;
    logic e;
    soft_clip_level_pin <= 8'h10;
    tick(5);
    chk(soft_clip_active, 1, "clip on");
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk(r, 32'h2000, "clip limit");
    push(16'h3000);
    take(16'h2000, 16'h2000);
    push(16'hd000);
    take(16'he000, 16'he000);
    push(16'h0800);
    take(16'h1000, 16'h1000);
    soft_clip_level_pin <= 8'hff;
    tick(5);
    chk(soft_clip_active, 0, "clip off");
    $display("t_clip done");
  endtask
  task t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000, "unmapped");
    apb(1'b1, 8'h00, 32'hffffffff, r, e);
    apb(1'b0, 8'h00, 32'h0, r, e);
    chk(r, 32'h1f, "ctrl bits");
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk(r[9:0], 10'h320, "status pins");
    apb(1'b1, 8'h00, 32'h1, r, e);
    $display("t_regs done");
  endtask
  task t_sleep;
    want_sleep <= 1'b1;
    wait_hz(1'b1);
    chk({output_highz, switching_enable, signal_path_run}, 3'b101, "sleep");
    want_sleep <= 1'b0;
    wait_run;
    chk(output_highz, 0, "wake");
    $display("t_sleep done");
  endtask
  task t_sw;
    logic [31:0] r;
    logic e;
    want_on <= 1'b0;
    tick(200);
    chk({signal_path_run, output_highz}, 2'b01, "shutdown");
    want_gain <= 2'b11;
    tick(5);
    want_on <= 1'b1;
    tick(60);
    chk({software_control_mode, i2s_only}, 2'b10, "software mode");
    chk(pwm_rate_multiple, 8, "ctrl rate");
    chk(signal_path_run, 1, "release");
    apb(1'b1, 8'h00, 32'h12, r, e);
    tick(2);
    chk({paralleled_bridge_mode, analog_gain_code}, 3'b110, "ctrl par gain");
    $display("t_sw done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_hw;
    t_stream;
    t_clip;
    t_regs;
    t_sleep;
    t_sw;
    tally_and_finish;
  end
endmodule
